/* rtl/nvm_guard_pkg.sv */
/*
 * Shared constants and carrier types for the memory write guard and
 * table read block: register offsets, control bit positions, unlock keys,
 * area codes and the readable address ranges of the configuration space.
 * Assumes a 32-bit APB register bus and a byte-wide flash array port.
 */
package nvm_guard_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] UNLOCK_OFS = 8'h04;
    localparam logic [7:0] POINTER_OFS = 8'h08;
    localparam logic [7:0] LATCH_OFS = 8'h0C;

    // ************************************************************
    // memory_control_one fields
    // ************************************************************
    localparam int READ_BIT = 0;
    localparam int TRIGGER_BIT = 1;
    localparam int PERMIT_BIT = 2;
    localparam int FAULT_BIT = 3;
    localparam int AREA_LSB = 6;
    localparam int AREA_MSB = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ************************************************************
    // Unlock keys, area codes, widths
    // ************************************************************
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam int ADDR_W = 22;
    localparam logic [1:0] AREA_FLASH = 2'h0;
    localparam logic [1:0] AREA_CFG_A = 2'h1;
    localparam logic [1:0] AREA_CFG_B = 2'h3;
    localparam logic [ADDR_W-1:0] POINTER_RESET = 22'h00_0000;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] FLASH_TOP = 22'h00_7FFF;

    // ************************************************************
    // Readable windows of the configuration space
    // ************************************************************
    localparam int RANGE_COUNT = 4;
    localparam logic [RANGE_COUNT-1:0][ADDR_W-1:0] RANGE_LO = {
        22'h3F_FFFC, 22'h3F_0000, 22'h30_0000, 22'h20_0000};
    localparam logic [RANGE_COUNT-1:0][ADDR_W-1:0] RANGE_HI = {
        22'h3F_FFFF, 22'h3F_003F, 22'h30_0009, 22'h20_000F};

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } flash_req_t;

    typedef enum logic [1:0] {
        UNLOCK_NONE = 2'b00,
        UNLOCK_HALF = 2'b01,
        UNLOCK_ARMED = 2'b10
    } unlock_state_t;

endpackage

/* rtl/area_range_check.sv */
/*
 * Address legality check for table reads. Holds only combinational logic.
 * Assumes the area code and pointer are stable while a read is pending.
 */
module area_range_check (
    input wire logic [1:0] area,
    input wire logic [nvm_guard_pkg::ADDR_W-1:0] addr,
    output logic in_range
);

    logic [nvm_guard_pkg::RANGE_COUNT-1:0] hit;
    logic cfg_area;

    // ************************************************************
    // One comparator pair per readable window
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < nvm_guard_pkg::RANGE_COUNT; i++) begin : g_win
            assign hit[i] = (addr >= nvm_guard_pkg::RANGE_LO[i]) &&
                            (addr <= nvm_guard_pkg::RANGE_HI[i]);
        end
    endgenerate

    assign cfg_area = (area == nvm_guard_pkg::AREA_CFG_A) ||
                      (area == nvm_guard_pkg::AREA_CFG_B);

    always_comb begin
        if (cfg_area) begin
            in_range = |hit;
        end else if (area == nvm_guard_pkg::AREA_FLASH) begin
            in_range = (addr <= nvm_guard_pkg::FLASH_TOP);
        end else begin
            in_range = 1'b0;
        end
    end

endmodule

/* rtl/nvm_write_guard.sv */
/*
 * Write guard and table read engine of the non-volatile memory controller.
 * Software reaches it over APB; the far side is a byte-wide flash port
 * with request/acknowledge handshakes. Reset causes arrive as levels
 * that are valid while sys_rst is high.
 */
// The address map and register access over APB were chosen for this implementation.
// Operation
// - A pin or watchdog reset that cuts a write short sets the program fault flag.
// - The program trigger only sets, and a write only starts, while the permit bit is set.
// - Hardware clears the permit bit only on reset; otherwise it holds the last value software wrote.
// - Each write needs a fresh unlock sequence plus the permit bit before it is accepted.
// - Area codes 01 and 11 point table reads at the configuration and identity space.
// - A table read copies the byte at the table pointer into the table latch.
// - The bus master is held in wait states until the table read byte is in the latch.
// - A table read outside the readable windows clears the table latch to zero.
module nvm_write_guard (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic power_on_reset,
    input wire logic reset_from_pin,
    input wire logic reset_from_watchdog,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output nvm_guard_pkg::flash_req_t flash_req,
    input wire logic flash_rd_ack,
    input wire logic [7:0] flash_rd_data,
    input wire logic flash_wr_done
);

    // ************************************************************
    // Storage
    // ************************************************************
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    nvm_guard_pkg::flash_req_t flash_req_reg;
    nvm_guard_pkg::seq_state_t state_reg;
    nvm_guard_pkg::unlock_state_t unlock_reg;

    logic [1:0] area_reg;
    logic permit_reg;
    logic fault_reg;
    logic rd_pend_reg;

    logic [nvm_guard_pkg::ADDR_W-1:0] pointer_reg;
    logic [7:0] latch_reg;

    logic setup;
    logic access;
    logic mapped;
    logic rd_cmd;
    logic ctrl_wr;

    logic trig_ok;
    logic in_range;
    logic read_done;

    logic [7:0] ctrl_view;
    logic [31:0] read_mux;

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign flash_req = flash_req_reg;

    // ************************************************************
    // Bus decode
    // ************************************************************
    // Setup opens a transfer; access is the edge where it lands
    assign setup = psel && !penable;
    assign access = psel && penable && pready_reg;

    // Unknown offsets answer with an error
    assign mapped = (paddr == nvm_guard_pkg::CTRL_OFS) ||
                    (paddr == nvm_guard_pkg::UNLOCK_OFS) ||
                    (paddr == nvm_guard_pkg::POINTER_OFS) ||
                    (paddr == nvm_guard_pkg::LATCH_OFS);

    // A read command is taken at setup so the stall starts at once
    assign rd_cmd = setup && pwrite && (paddr == nvm_guard_pkg::CTRL_OFS) &&
                    pwdata[nvm_guard_pkg::READ_BIT];
    assign ctrl_wr = access && pwrite && (paddr == nvm_guard_pkg::CTRL_OFS);

    // Trigger accepted only when permitted, freshly unlocked and idle
    assign trig_ok = ctrl_wr && pwdata[nvm_guard_pkg::TRIGGER_BIT] && permit_reg &&
                     (unlock_reg == nvm_guard_pkg::UNLOCK_ARMED) &&
                     (state_reg == nvm_guard_pkg::ST_IDLE);

    // Out-of-range reads finish without touching the array
    assign read_done = (state_reg == nvm_guard_pkg::ST_READ) &&
                       (!in_range || (flash_req_reg.rd && flash_rd_ack));

    // Trigger and read bits read back as busy flags
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[nvm_guard_pkg::AREA_MSB:nvm_guard_pkg::AREA_LSB] = area_reg;
        ctrl_view[nvm_guard_pkg::FAULT_BIT] = fault_reg;
        ctrl_view[nvm_guard_pkg::PERMIT_BIT] = permit_reg;
        ctrl_view[nvm_guard_pkg::TRIGGER_BIT] = (state_reg == nvm_guard_pkg::ST_WRITE);
        ctrl_view[nvm_guard_pkg::READ_BIT] = rd_pend_reg;
    end

    // Write-only and unmapped offsets read as zero
    always_comb begin
        unique case (paddr)
            nvm_guard_pkg::CTRL_OFS: read_mux = {24'h00_0000, ctrl_view};
            nvm_guard_pkg::POINTER_OFS: read_mux = {10'h000, pointer_reg};
            nvm_guard_pkg::LATCH_OFS: read_mux = {24'h00_0000, latch_reg};
            default: read_mux = 32'h0000_0000;
        endcase
    end

    // Checks the registered area and pointer
    area_range_check u_range (
        .area(area_reg),
        .addr(pointer_reg),
        .in_range(in_range)
    );

    // ************************************************************
    // APB answer
    // ************************************************************
    // Ordinary accesses answer one cycle after setup; a table read
    // command holds pready low until the latch is loaded.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            if (setup && !rd_cmd) begin
                pready_reg <= 1'b1;
                pslverr_reg <= !mapped;
                prdata_reg <= pwrite ? 32'h0000_0000 : read_mux;
            end else if (read_done) begin
                pready_reg <= 1'b1;
                prdata_reg <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rd_pend_reg <= 1'b0;
        end else if (rd_cmd) begin
            rd_pend_reg <= 1'b1;
        end else if (read_done) begin
            rd_pend_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    // A pending read wins over a trigger in the same cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg <= nvm_guard_pkg::ST_IDLE;
        end else begin
            unique case (state_reg)
                nvm_guard_pkg::ST_IDLE: begin
                    if (rd_pend_reg) begin
                        state_reg <= nvm_guard_pkg::ST_READ;
                    end else if (trig_ok) begin
                        state_reg <= nvm_guard_pkg::ST_WRITE;
                    end
                end
                nvm_guard_pkg::ST_READ: begin
                    if (read_done) begin
                        state_reg <= nvm_guard_pkg::ST_IDLE;
                    end
                end
                nvm_guard_pkg::ST_WRITE: begin
                    if (flash_req_reg.wr && flash_wr_done) begin
                        state_reg <= nvm_guard_pkg::ST_IDLE;
                    end
                end
                default: state_reg <= nvm_guard_pkg::ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Flash port
    // ************************************************************
    // Requests are levels held until the array answers;
    // a reset drops them, so the array must abort on it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flash_req_reg <= '0;
        end else begin
            if (state_reg == nvm_guard_pkg::ST_IDLE && rd_pend_reg) begin
                flash_req_reg.addr <= pointer_reg;
            end else if (trig_ok && !rd_pend_reg) begin
                flash_req_reg.wr <= 1'b1;
                flash_req_reg.addr <= pointer_reg;
                flash_req_reg.wdata <= latch_reg;
            end
            if (state_reg == nvm_guard_pkg::ST_READ && in_range &&
                !flash_req_reg.rd && !flash_rd_ack) begin
                flash_req_reg.rd <= 1'b1;
            end else if (flash_req_reg.rd && flash_rd_ack) begin
                flash_req_reg.rd <= 1'b0;
            end
            if (flash_req_reg.wr && flash_wr_done) begin
                flash_req_reg.wr <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Unlock sequence
    // ************************************************************
    // Any other write breaks a half-done sequence; any trigger attempt
    // consumes an armed one, so every write needs its own sequence.
    // Idle cycles between the two keys do not break it.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            unlock_reg <= nvm_guard_pkg::UNLOCK_NONE;
        end else if (access && pwrite) begin
            if (paddr == nvm_guard_pkg::UNLOCK_OFS) begin
                if (pwdata[7:0] == nvm_guard_pkg::KEY_FIRST) begin
                    unlock_reg <= nvm_guard_pkg::UNLOCK_HALF;
                end else if (pwdata[7:0] == nvm_guard_pkg::KEY_SECOND &&
                             unlock_reg == nvm_guard_pkg::UNLOCK_HALF) begin
                    unlock_reg <= nvm_guard_pkg::UNLOCK_ARMED;
                end else begin
                    unlock_reg <= nvm_guard_pkg::UNLOCK_NONE;
                end
            end else if (ctrl_wr && pwdata[nvm_guard_pkg::TRIGGER_BIT]) begin
                unlock_reg <= nvm_guard_pkg::UNLOCK_NONE;
            end else if (unlock_reg == nvm_guard_pkg::UNLOCK_HALF) begin
                unlock_reg <= nvm_guard_pkg::UNLOCK_NONE;
            end
        end
    end

    // ************************************************************
    // Control fields
    // ************************************************************
    // Permit changes only by a software write or a reset, never by the sequencer.
    // A read command uses the area already in place: set the area
    // with an earlier write before asking for a read.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            permit_reg <= nvm_guard_pkg::CTRL_RESET[nvm_guard_pkg::PERMIT_BIT];
            area_reg <= nvm_guard_pkg::CTRL_RESET[nvm_guard_pkg::AREA_MSB:nvm_guard_pkg::AREA_LSB];
        end else if (ctrl_wr) begin
            permit_reg <= pwdata[nvm_guard_pkg::PERMIT_BIT];
            area_reg <= pwdata[nvm_guard_pkg::AREA_MSB:nvm_guard_pkg::AREA_LSB];
        end
    end

    // The fault flag is the one control bit that a warm reset keeps:
    // of the resets only power-on clears it, so software can see the cut write.
    // Set only under reset, software clear only outside it; power-on wins over a set.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            if (power_on_reset) begin
                fault_reg <= 1'b0;
            end else if (state_reg == nvm_guard_pkg::ST_WRITE &&
                         (reset_from_pin || reset_from_watchdog)) begin
                fault_reg <= 1'b1;
            end
        end else if (ctrl_wr && !pwdata[nvm_guard_pkg::FAULT_BIT]) begin
            fault_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Pointer and latch
    // ************************************************************
    // Upper pointer bits from the bus are dropped
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pointer_reg <= nvm_guard_pkg::POINTER_RESET;
        end else if (access && pwrite && paddr == nvm_guard_pkg::POINTER_OFS) begin
            pointer_reg <= pwdata[nvm_guard_pkg::ADDR_W-1:0];
        end
    end

    // Software loads the latch with write data; a table read overwrites it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            latch_reg <= nvm_guard_pkg::LATCH_RESET;
        end else if (read_done) begin
            latch_reg <= in_range ? flash_rd_data : 8'h00;
        end else if (access && pwrite && paddr == nvm_guard_pkg::LATCH_OFS) begin
            latch_reg <= pwdata[7:0];
        end
    end

endmodule

/* testbench/nvm_guard_sva.sv */
/* Port-level checker for nvm_write_guard: APB answer timing, flash handshakes and
   the write gate. Assumes it is bound to the design and the APB master holds requests. */
module nvm_guard_sva (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic power_on_reset,
    input wire logic reset_from_pin,
    input wire logic reset_from_watchdog,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire nvm_guard_pkg::flash_req_t flash_req,
    input wire logic flash_rd_ack,
    input wire logic [7:0] flash_rd_data,
    input wire logic flash_wr_done
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Helpers
    // ****
    logic permit_seen;
    logic mapped;
    logic plain_setup;
    assign mapped = paddr inside {nvm_guard_pkg::CTRL_OFS, nvm_guard_pkg::UNLOCK_OFS,
        nvm_guard_pkg::POINTER_OFS, nvm_guard_pkg::LATCH_OFS};
    assign plain_setup = psel && !penable && !(pwrite && paddr == nvm_guard_pkg::CTRL_OFS
        && pwdata[nvm_guard_pkg::READ_BIT]);
    // Permit as software last wrote it, so a write start can be traced to it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            permit_seen <= 1'b0;
        end else if (psel && penable && pready && pwrite
            && paddr == nvm_guard_pkg::CTRL_OFS) begin
            permit_seen <= pwdata[nvm_guard_pkg::PERMIT_BIT];
        end
    end
    // ****
    // Properties
    // ****
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    sequence rd_taken;
        flash_req.rd && flash_rd_ack;
    endsequence
    sequence rd_closed;
        !flash_req.rd && pready && !pslverr;
    endsequence
    pulse_once_a: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    ordinary_wait_a: assert property (plain_setup |=> pready && pslverr == !mapped)
        else $error("plain access not answered at once");
    rd_hold_a: assert property (flash_req.rd && !flash_rd_ack |=>
        flash_req.rd && $stable(flash_req.addr)) else $error("flash read dropped early");
    rd_answer_a: assert property (rd_taken |=> rd_closed)
        else $error("table read not released after ack");
    wr_hold_a: assert property (flash_req.wr && !flash_wr_done |=>
        flash_req.wr && $stable(flash_req.wdata)) else $error("flash write dropped early");
    wr_end_a: assert property (flash_req.wr && flash_wr_done |=> !flash_req.wr)
        else $error("flash write held after done");
    wr_permit_a: assert property ($rose(flash_req.wr) |-> permit_seen)
        else $error("write started without permit");
    no_overlap_a: assert property (!(flash_req.rd && flash_req.wr))
        else $error("read and write requested together");
    reset_clear_a: assert property (disable iff (1'b0) sys_rst |=> !pready && flash_req == '0)
        else $error("outputs not cleared by reset");
endmodule

bind nvm_write_guard nvm_guard_sva i_sva (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .power_on_reset(power_on_reset), .reset_from_pin(reset_from_pin),
    .reset_from_watchdog(reset_from_watchdog), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_req(flash_req), .flash_rd_ack(flash_rd_ack),
    .flash_rd_data(flash_rd_data), .flash_wr_done(flash_wr_done));

/* testbench/flash_array_model.sv */
/* Behavioural flash array behind the guard: answers reads and writes dly+1 cycles after the request.
   Assumes rd and wr are held until acknowledged; reset aborts any operation. */
module flash_array_model (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire nvm_guard_pkg::flash_req_t flash_req,
    output logic flash_rd_ack,
    output logic [7:0] flash_rd_data,
    output logic flash_wr_done
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Array behaviour
    // ****
    int dly = 1;
    int cnt = 0;
    int wr_count = 0;
    logic [21:0] wr_addr;
    logic [7:0] wr_data;
    initial begin
        flash_rd_ack = 1'b0;
        flash_rd_data = 8'h00;
        flash_wr_done = 1'b0;
    end
    always @(posedge sys_clk) begin
        flash_rd_ack <= 1'b0;
        flash_wr_done <= 1'b0;
        // Idle data changes every cycle so a stale byte is never mistaken for an answer
        flash_rd_data <= ~flash_rd_data;
        if (sys_rst || flash_rd_ack || flash_wr_done || !(flash_req.rd || flash_req.wr)) begin
            cnt <= 0;
        end else if (cnt < dly) begin
            cnt <= cnt + 1;
        end else if (flash_req.rd) begin
            flash_rd_ack <= 1'b1;
            flash_rd_data <= flash_req.addr[7:0] ^ 8'hC3;
        end else begin
            flash_wr_done <= 1'b1;
            wr_count <= wr_count + 1;
            wr_addr <= flash_req.addr;
            wr_data <= flash_req.wdata;
        end
    end
endmodule

/* testbench/nvm_write_guard_and_config_read_bench.sv */
/* Bench for nvm_write_guard: APB tasks run software sequences against a flash model.
   Assumes a 20 MHz sys_clk and a synchronous active-high reset. */
module nvm_write_guard_and_config_read_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Signals, tasks and tests
    // ****
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic power_on_reset = 1'b1;
    logic reset_from_pin = 1'b0;
    logic reset_from_watchdog = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    nvm_guard_pkg::flash_req_t flash_req;
    logic flash_rd_ack;
    logic [7:0] flash_rd_data;
    logic flash_wr_done;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    int base;
    logic [31:0] rdat;
    logic rerr;
    logic [7:0] lat;
    logic [1:0] areas [12] = '{1, 1, 3, 3, 1, 1, 3, 0, 0, 3, 2, 1};
    logic [21:0] ptrs [12] = '{22'h20_000F, 22'h20_0010, 22'h30_0009, 22'h30_000A,
        22'h3F_003F, 22'h3F_0040, 22'h3F_FFFC, 22'h00_7FFF, 22'h00_8000, 22'h3F_FFFF,
        22'h20_0000, 22'h20_0003};
    logic [0:11] inr = 12'hAB5;

    always #25 sys_clk = ~sys_clk;

    nvm_write_guard i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .power_on_reset(power_on_reset), .reset_from_pin(reset_from_pin),
        .reset_from_watchdog(reset_from_watchdog), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_req(flash_req), .flash_rd_ack(flash_rd_ack),
        .flash_rd_data(flash_rd_data), .flash_wr_done(flash_wr_done));
    flash_array_model i_flash (.sys_clk(sys_clk), .sys_rst(sys_rst), .flash_req(flash_req),
        .flash_rd_ack(flash_rd_ack), .flash_rd_data(flash_rd_data),
        .flash_wr_done(flash_wr_done));

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles >= 20000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, exp, rdat);
    endtask

    task automatic unlock;
        apb(1'b1, nvm_guard_pkg::UNLOCK_OFS, {24'h00_0000, nvm_guard_pkg::KEY_FIRST});
        apb(1'b1, nvm_guard_pkg::UNLOCK_OFS, {24'h00_0000, nvm_guard_pkg::KEY_SECOND});
    endtask

    task automatic try_write(input string name, input logic unl, input logic [31:0] ctl,
        input logic [31:0] inc);
        base = i_flash.wr_count;
        if (unl) begin
            unlock();
        end
        apb(1'b1, nvm_guard_pkg::CTRL_OFS, ctl);
        rdat = 32'h0000_0002;
        while (rdat[1] !== 1'b0) begin
            apb(1'b0, nvm_guard_pkg::CTRL_OFS, 32'h0000_0000);
        end
        chk(name, inc, i_flash.wr_count - base);
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        power_on_reset <= 1'b0;
        rd("ctrl reset", nvm_guard_pkg::CTRL_OFS, 32'h0000_0000);
        rd("latch reset", nvm_guard_pkg::LATCH_OFS, 32'h0000_0000);
        rd("unmapped", 8'h10, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, {31'h0, rerr});
        apb(1'b1, nvm_guard_pkg::POINTER_OFS, 32'hFFFF_FFFF);
        rd("pointer width", nvm_guard_pkg::POINTER_OFS, 32'h003F_FFFF);
        $display("test map done");
        for (int i = 0; i < 12; i++) begin
            i_flash.dly = 1 + (i % 2) * 5;
            apb(1'b1, nvm_guard_pkg::POINTER_OFS, {10'h000, ptrs[i]});
            apb(1'b1, nvm_guard_pkg::CTRL_OFS, {24'h00_0000, areas[i], 6'h00});
            apb(1'b1, nvm_guard_pkg::CTRL_OFS, {24'h00_0000, areas[i], 6'h01});
            rd("table latch", nvm_guard_pkg::LATCH_OFS,
                inr[i] ? {24'h00_0000, ptrs[i][7:0] ^ 8'hC3} : 32'h0000_0000);
        end
        $display("test table read done");
        lat = rdat[7:0];
        apb(1'b1, nvm_guard_pkg::POINTER_OFS, 32'h0000_0123);
        apb(1'b1, nvm_guard_pkg::CTRL_OFS, 32'h0000_0004);
        try_write("no unlock", 1'b0, 32'h0000_0006, 32'h0000_0000);
        rd("permit kept", nvm_guard_pkg::CTRL_OFS, 32'h0000_0004);
        apb(1'b1, nvm_guard_pkg::CTRL_OFS, 32'h0000_0000);
        try_write("no permit", 1'b1, 32'h0000_0002, 32'h0000_0000);
        rd("trigger gated", nvm_guard_pkg::CTRL_OFS, 32'h0000_0000);
        apb(1'b1, nvm_guard_pkg::CTRL_OFS, 32'h0000_0004);
        try_write("unlocked", 1'b1, 32'h0000_0006, 32'h0000_0001);
        chk("write addr", 32'h0000_0123, {10'h000, i_flash.wr_addr});
        chk("write verify", {24'h00_0000, lat}, {24'h00_0000, i_flash.wr_data});
        rd("permit after write", nvm_guard_pkg::CTRL_OFS, 32'h0000_0004);
        try_write("reused unlock", 1'b0, 32'h0000_0006, 32'h0000_0000);
        apb(1'b1, nvm_guard_pkg::UNLOCK_OFS, {24'h00_0000, nvm_guard_pkg::KEY_FIRST});
        apb(1'b1, nvm_guard_pkg::POINTER_OFS, 32'h0000_0123);
        apb(1'b1, nvm_guard_pkg::UNLOCK_OFS, {24'h00_0000, nvm_guard_pkg::KEY_SECOND});
        try_write("broken unlock", 1'b0, 32'h0000_0006, 32'h0000_0000);
        apb(1'b1, nvm_guard_pkg::CTRL_OFS, 32'h0000_0000);
        $display("test write guard done");
        i_flash.dly = 30;
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, nvm_guard_pkg::CTRL_OFS, 32'h0000_0004);
            unlock();
            apb(1'b1, nvm_guard_pkg::CTRL_OFS, 32'h0000_0006);
            @(posedge sys_clk);
            sys_rst <= 1'b1;
            reset_from_pin <= (k == 0 || k == 3);
            reset_from_watchdog <= (k == 1);
            repeat (4) @(posedge sys_clk);
            sys_rst <= 1'b0;
            reset_from_pin <= 1'b0;
            reset_from_watchdog <= 1'b0;
            rd("fault flag", nvm_guard_pkg::CTRL_OFS, (k == 2) ? 0 : 8);
        end
        apb(1'b1, nvm_guard_pkg::CTRL_OFS, 32'h0000_0008);
        rd("fault kept", nvm_guard_pkg::CTRL_OFS, 32'h0000_0008);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        power_on_reset <= 1'b1;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        power_on_reset <= 1'b0;
        rd("fault after power on", nvm_guard_pkg::CTRL_OFS, 32'h0000_0000);
        $display("test fault flag done");
        final_report();
    end
endmodule
